/* File: bench/cdi_btn_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// Pushbutton with pull-up and contact bounce, pressed in bursts
module cdi_btn_model (
  input wire clk_in,
  input wire go_in,
  input wire [2:0] count_in,
  output reg button_n_out,
  output reg busy_out
);
  integer i; // Press index
  // One edge of a press: chatter, then a long settled level
  task settle(input lvl);
    begin
      repeat (6) begin
        @(posedge clk_in);
        button_n_out <= ~button_n_out;
      end
      @(posedge clk_in);
      button_n_out <= lvl;
      repeat (400) @(posedge clk_in);
    end
  endtask
  // Burst runner; idle level is the pull-up
  initial begin
    button_n_out = 1'b1;
    busy_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (go_in) begin
        busy_out <= 1'b1;
        // burst ends far inside the window
        for (i = 0; i < count_in; i = i + 1) begin
          settle(1'b0);
          settle(1'b1);
        end
        busy_out <= 1'b0;
      end
    end
  end
endmodule // cdi_btn_model

/* File: bench/cdi_props.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// Port-level checks on the indicator block
module cdi_props #(
  parameter TICK_CYCLES = 10
) (
  input wire core_clk_in,
  input wire nrst_in,
  input wire psel_in,
  input wire penable_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire mac_ack_fail_in,
  input wire tx_nack_opt_in,
  input wire nid_rx_in,
  input wire [15:0] nid_rx_addr_in,
  input wire nid_fwd_out,
  input wire [15:0] nid_fwd_addr_out,
  input wire route_info_out,
  input wire assoc_led_out,
  input wire assoc_led_oe_out,
  input wire nid_tx_out,
  input wire restore_defaults_out
);
  // Single clock domain, so one default each
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////
  // Bus answers after exactly one wait state, for one cycle
  a_apb_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
    else $error("bus answer timing wrong");
  // Refused access reads back zero
  a_err_zero: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error answer malformed");
  a_route_nack: assert property (mac_ack_fail_in && tx_nack_opt_in |=> route_info_out)
    else $error("route report missing");
  a_route_cause: assert property (route_info_out |-> $past(mac_ack_fail_in && tx_nack_opt_in))
    else $error("route report without cause");
  a_fwd_source: assert property (nid_fwd_out |-> $past(nid_rx_in) && nid_fwd_addr_out == $past(nid_rx_addr_in))
    else $error("forwarded frame wrong");
  a_led_driven: assert property (assoc_led_out |-> assoc_led_oe_out)
    else $error("led lit while not driven");
  a_tx_pulse: assert property (nid_tx_out |=> !nid_tx_out)
    else $error("broadcast strobe too long");
  a_restore_pulse: assert property (restore_defaults_out |=> !restore_defaults_out)
    else $error("restore strobe too long");
  // Main scenarios reached
  c_route: cover property (route_info_out);
  c_fwd: cover property (nid_fwd_out);
  c_restore: cover property (restore_defaults_out);
endmodule // cdi_props

bind cdi_top cdi_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .mac_ack_fail_in(mac_ack_fail_in), .tx_nack_opt_in(tx_nack_opt_in), .nid_rx_in(nid_rx_in),
  .nid_rx_addr_in(nid_rx_addr_in), .nid_fwd_out(nid_fwd_out), .nid_fwd_addr_out(nid_fwd_addr_out),
  .route_info_out(route_info_out), .assoc_led_out(assoc_led_out), .assoc_led_oe_out(assoc_led_oe_out),
  .nid_tx_out(nid_tx_out), .restore_defaults_out(restore_defaults_out)
);

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`include "cdi_defines.vh"
////////////////////////////////////////////////////////////////
// Self-checking bench for the indicator block
module testbench;
  localparam integer TK = 10; // Short tick keeps the run small
  reg clk = 1'b0, nrst = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h00, rssi = 8'h00;
  reg [31:0] pwdata = 32'h0, rv, nm;
  reg pkt = 0, mac = 0, nack = 0, nrx = 0, awake = 0, wstart = 0, go = 0, re;
  reg [15:0] rxa = 16'h0, ad;
  reg [2:0] pcnt = 3'h0;
  wire btn_n, busy, pwm, led, oe, ntx, fwd, route, rst_o, whold, irq, prdy, perr;
  wire [31:0] prdata, name_o;
  wire [15:0] txa, fwda;
  wire [2:0] txs;
  integer n_mismatch = 0, checked = 0, cyc = 0, n_tx = 0, n_rd = 0, n_fw = 0, n_rs = 0;
  integer g, h, b, rssi_m; // Scratch and model values
  ////////////////////////////////////////////////////////////////
  cdi_top #(.TICK_CYCLES(TK)) dut_u (.core_clk_in(clk), .nrst_in(nrst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr), .pkt_rx_in(pkt), .pkt_rssi_in(rssi),
    .mac_ack_fail_in(mac), .tx_nack_opt_in(nack), .nid_rx_in(nrx), .nid_rx_addr_in(rxa),
    .awake_in(awake), .wake_start_in(wstart), .button_n_in(btn_n), .rssi_pwm_pin_out(pwm),
    .assoc_led_out(led), .assoc_led_oe_out(oe), .nid_tx_out(ntx), .nid_tx_addr_out(txa),
    .nid_tx_name_out(name_o), .nid_tx_sleep_out(txs), .nid_fwd_out(fwd), .nid_fwd_addr_out(fwda),
    .route_info_out(route), .restore_defaults_out(rst_o), .wake_hold_out(whold), .irq_out(irq));
  cdi_btn_model btn_u (.clk_in(clk), .go_in(go), .count_in(pcnt), .button_n_out(btn_n), .busy_out(busy));
  always #10 clk = ~clk;
  // Hang guard and strobe counters
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 99000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
    if (ntx === 1'b1) n_tx = n_tx + 1;
    if (route === 1'b1) n_rd = n_rd + 1;
    if (fwd === 1'b1) n_fw = n_fw + 1;
    if (rst_o === 1'b1) n_rs = n_rs + 1;
  end
  ////////////////////////////////////////////////////////////////
  task stop_test;
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp, input string msg);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
    end
  endtask
  // One bus transfer; idle cycle after so calls never collide
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      // Wait for the answer; no timeout here, only the hang guard ends a stall
      while (prdy !== 1'b1) @(posedge clk);
      rv = prdata;
      re = perr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input string m);
    begin
      apb(0, a, 32'h0);
      check(rv, e, m);
    end
  endtask
  // One-cycle strobe on a chosen event input
  task pulse(input integer k);
    begin
      case (k)
        0: pkt <= 1;
        1: mac <= 1;
        2: nrx <= 1;
        default: wstart <= 1;
      endcase
      @(posedge clk);
      pkt <= 0; mac <= 0; nrx <= 0; wstart <= 0;
      // Strobe counters see the answer before the caller looks
      repeat (2) @(posedge clk);
    end
  endtask
  // Length of one full indicator phase, first partial one skipped
  task led_gap(output integer gg);
    reg l;
    begin
      gg = 0;
      l = led;
      while (led === l && gg < 6000) begin @(posedge clk); gg = gg + 1; end
      l = led;
      gg = 0;
      while (led === l && gg < 6000) begin @(posedge clk); gg = gg + 1; end
    end
  endtask
  task led_edges(output integer e);
    reg l;
    begin
      e = 0;
      // Skip the edge that still shows the old setting
      @(posedge clk);
      l = led;
      repeat (3000) begin @(posedge clk); if (led !== l) e = e + 1; l = led; end
    end
  endtask
  function integer near(input integer v, input integer e);
    near = (v >= e - TK && v <= e + TK);
  endfunction
  function integer cnt(input integer k);
    cnt = (k == 0) ? n_tx : n_rs;
  endfunction
  task wait_more(input integer k, input integer base, input integer lim);
    integer c;
    begin
      c = 0;
      while (cnt(k) == base && c < lim) begin @(posedge clk); c = c + 1; end
      repeat (2) @(posedge clk);
    end
  endtask
  task press(input [2:0] n);
    begin
      pcnt <= n; go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (2) @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(96005));
    repeat (20) @(posedge clk);
    nrst <= 1;
    repeat (2) @(posedge clk);
    check(oe, 1, "led enable");
    rd(`CDI_REG_CTRL, 32'h6, "ctrl reset");
    rd(`CDI_REG_BLINK, 32'h0, "blink reset");
    rd(8'h20, 32'h0, "hole");
    check(re, 1, "hole error");
    rd(8'h02, 32'h0, "unaligned");
    check(re, 1, "unaligned error");
    $display("test reset done");
    // Strength register and PWM, two packets in a row
    h = 0;
    repeat (256) begin @(posedge clk); if (pwm === 1'b1) h = h + 1; end
    check(h, 0, "pwm off");
    apb(1, `CDI_REG_CTRL, 32'h07);
    for (b = 0; b < 2; b = b + 1) begin
      rssi_m = $urandom % 256;
      rssi <= rssi_m;
      pulse(0);
      rd(`CDI_REG_RSSI, rssi_m, "rssi");
      apb(1, `CDI_REG_RSSI, 32'hff);
      rd(`CDI_REG_RSSI, rssi_m, "rssi ro");
      repeat (300) @(posedge clk);
      h = 0;
      repeat (256) begin @(posedge clk); if (pwm === 1'b1) h = h + 1; end
      check(h, 255 - rssi_m, "pwm duty");
    end
    $display("test rssi done");
    // Route report, status, mask and interrupt
    apb(1, `CDI_REG_MASK, 32'h0);
    nack <= 1;
    pulse(1);
    repeat (3) @(posedge clk);
    check(n_rd, 1, "route sent");
    rd(`CDI_REG_STATUS, 32'h2, "status route");
    check(irq, 0, "irq masked");
    apb(1, `CDI_REG_MASK, 32'h1f);
    repeat (2) @(posedge clk);
    check(irq, 1, "irq raised");
    apb(1, `CDI_REG_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    check(irq, 0, "irq cleared");
    nack <= 0;
    pulse(1);
    repeat (3) @(posedge clk);
    check(n_rd, 1, "no route");
    $display("test route done");
    // Blink periods, then a received broadcast
    apb(1, `CDI_REG_CTRL, 32'h0e);
    apb(1, `CDI_REG_BLINK, 32'h3);
    led_gap(g);
    check(near(g, 30 * TK), 1, "blink override");
    apb(1, `CDI_REG_BLINK, 32'h0);
    led_gap(g);
    check(near(g, 250 * TK), 1, "blink default");
    ad = $urandom;
    rxa <= ad;
    pulse(2);
    check(n_fw, 1, "fwd sent");
    check(fwda, ad, "fwd addr");
    led_gap(g);
    check(near(g, 50 * TK), 1, "fast blink");
    apb(1, `CDI_REG_CTRL, 32'h06);
    pulse(2);
    check(n_fw, 1, "no fwd");
    $display("test indicator done");
    // Indicator in sleep mode 1
    apb(1, `CDI_REG_CTRL, 32'h16);
    led_edges(g);
    check(g, 0, "asleep edges");
    check(led, 0, "asleep off");
    awake <= 1;
    led_edges(g);
    check(g > 0, 1, "awake blink");
    $display("test sleep done");
    // Simulated presses
    ad = $urandom;
    nm = $urandom;
    apb(1, `CDI_REG_ADDR, ad);
    apb(1, `CDI_REG_NAME, nm);
    apb(1, `CDI_REG_CTRL, 32'h06);
    b = n_tx;
    apb(1, `CDI_REG_BTN, 32'h1);
    wait_more(0, b, 20);
    check(n_tx, b + 1, "sim press");
    check(txa, ad, "tx addr");
    check(name_o, nm, "tx name");
    check(txs, 0, "tx sleep");
    apb(1, `CDI_REG_CTRL, 32'h16);
    b = n_tx;
    apb(1, `CDI_REG_BTN, 32'h1);
    repeat (50) @(posedge clk);
    check(n_tx, b, "held to wake");
    pulse(3);
    repeat (2) @(posedge clk);
    check(n_tx, b + 1, "sent at wake");
    check(txs, 1, "tx sleep 1");
    apb(1, `CDI_REG_CTRL, 32'h96);
    b = n_tx;
    apb(1, `CDI_REG_BTN, 32'h1);
    wait_more(0, b, 20);
    check(n_tx, b + 1, "async send");
    check(whold, 1, "wake hold");
    b = n_rs;
    apb(1, `CDI_REG_BTN, 32'h4);
    wait_more(1, b, 20);
    check(n_rs, b + 1, "sim restore");
    b = n_tx;
    h = n_rs;
    apb(1, `CDI_REG_BTN, 32'h2);
    repeat (20) @(posedge clk);
    check(n_tx + n_rs, b + h, "two presses");
    $display("test simulate done");
    // Physical presses with bounce
    apb(1, `CDI_REG_CTRL, 32'h06);
    b = n_tx;
    press(1);
    wait_more(0, b, 25000);
    check(n_tx, b + 1, "button single");
    b = n_rs;
    h = n_tx;
    press(4);
    wait_more(1, b, 25000);
    check(n_rs, b + 1, "button restore");
    check(n_tx, h, "no broadcast");
    apb(1, `CDI_REG_CTRL, 32'h02);
    b = n_tx;
    press(1);
    repeat (22000) @(posedge clk);
    check(n_tx, b, "button disabled");
    $display("test button done");
    stop_test;
  end
endmodule // testbench

/* File: common/cdi_defines.vh */
// Overview of operation
// [RULE1] NACK option plus hop ack failure reports route
// [RULE2] Signal strength query returns last packet magnitude
// [RULE3] PWM duty follows each received packet strength
// [RULE4] Indicator select one drives association pin output
// [RULE5] Blink override sets period, zero means 250ms
// [RULE6] Indicator blinks while awake, off while asleep
// [RULE7] Single press: broadcast now or next wake
// [RULE8] Received broadcast blinks indicator fast one second
// [RULE9] Pushbutton handled only when its select is one
// [RULE10] Presses counted within a two second window
// [RULE11] Asynchronous sleep: single press wakes thirty seconds
// [RULE12] Four presses restore all defaults
// [RULE13] API mode forwards received broadcast to serial
// [RULE14] Button simulation acts like physical presses
// [RULE15] Identification frame carries address, name, node data
// [RULE16] Pushbutton synchronised and debounced before counting
`ifndef CDI_DEFINES_VH
`define CDI_DEFINES_VH
// Register byte offsets
`define CDI_REG_CTRL 8'h00
`define CDI_REG_BLINK 8'h04
`define CDI_REG_RSSI 8'h08
`define CDI_REG_BTN 8'h0c
`define CDI_REG_STATUS 8'h10
`define CDI_REG_MASK 8'h14
`define CDI_REG_NAME 8'h18
`define CDI_REG_ADDR 8'h1c
// Control field positions
`define CDI_CTRL_RSSI_SEL 0
`define CDI_CTRL_ASSOC_SEL 1
`define CDI_CTRL_BTN_SEL 2
`define CDI_CTRL_API 3
`define CDI_CTRL_SM_LO 4
`define CDI_CTRL_SM_HI 6
`define CDI_CTRL_ASYNC 7
`define CDI_CTRL_RESET 8'h06
// Status bit positions
`define CDI_ST_NID_TX 0
`define CDI_ST_ROUTE 1
`define CDI_ST_NID_FWD 2
`define CDI_ST_RESTORE 3
`define CDI_ST_NID_RX 4
`define CDI_ST_W 5
// Timing, clock period and tick length in ns
`define CDI_CLK_NS 20
`define CDI_TICK_NS 1000000
// Times in ms
`define CDI_BLINK_DEF_MS 250
`define CDI_BLINK_UNIT_MS 10
`define CDI_FAST_HALF_MS 50
`define CDI_FAST_DUR_MS 1000
`define CDI_WINDOW_MS 2000
`define CDI_WAKE_MS 30000
`define CDI_DEBOUNCE_MS 20
// Press counts
`define CDI_PRESS_NID 3'h1
`define CDI_PRESS_RESTORE 3'h4
`endif

/* File: logic/cdi_top.v */
`timescale 1ns/100ps
`include "cdi_defines.vh"

module cdi_top #(
  parameter TICK_CYCLES = `CDI_TICK_NS / `CDI_CLK_NS
) (
  input wire core_clk_in,
  input wire nrst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire pkt_rx_in,
  input wire [7:0] pkt_rssi_in,
  input wire mac_ack_fail_in,
  input wire tx_nack_opt_in,
  input wire nid_rx_in,
  input wire [15:0] nid_rx_addr_in,
  input wire awake_in,
  input wire wake_start_in,
  input wire button_n_in,
  output wire rssi_pwm_pin_out,
  output wire assoc_led_out,
  output wire assoc_led_oe_out,
  output wire nid_tx_out,
  output wire [15:0] nid_tx_addr_out,
  output wire [31:0] nid_tx_name_out,
  output wire [2:0] nid_tx_sleep_out,
  output wire nid_fwd_out,
  output wire [15:0] nid_fwd_addr_out,
  output wire route_info_out,
  output wire restore_defaults_out,
  output wire wake_hold_out,
  output wire irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Derived counts in ms ticks
  localparam [15:0] FAST_HALF = `CDI_FAST_HALF_MS;
  localparam [15:0] FAST_DUR = `CDI_FAST_DUR_MS;
  localparam [15:0] WINDOW = `CDI_WINDOW_MS;
  localparam [15:0] WAKE_DUR = `CDI_WAKE_MS;
  localparam [15:0] DEBOUNCE = `CDI_DEBOUNCE_MS;
  localparam [15:0] BLINK_DEF = `CDI_BLINK_DEF_MS;
  localparam [15:0] BLINK_UNIT = `CDI_BLINK_UNIT_MS;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  // Button window states, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_COUNT = 2'b10;

  // Saturating decrement of a ms counter
  function [15:0] dec16;
    input [15:0] v;
    begin
      dec16 = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0] ctrl_q;
  reg [7:0] blink_time_override_q;
  reg [7:0] signal_strength_query_q;
  reg [`CDI_ST_W-1:0] status_q;
  reg [`CDI_ST_W-1:0] mask_q;
  reg [31:0] node_name_string_q;
  reg [15:0] own_addr_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg irq_q;
  // Button simulation request, one cycle
  reg sim_go_q;
  reg [2:0] sim_cnt_q;

  wire [2:0] sleep_mode = ctrl_q[`CDI_CTRL_SM_HI:`CDI_CTRL_SM_LO];
  // Any nonzero sleep mode counts as sleep compatible
  wire sleep_compat = (sleep_mode != 3'h0);
  wire apb_wr = psel_in & penable_in & pready_q & pwrite_in;
  wire addr_ok = (paddr_in[1:0] == 2'b00) && (paddr_in <= `CDI_REG_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Event pulses raised by the block
  reg nid_tx_q;
  reg nid_fwd_q;
  reg [15:0] nid_fwd_addr_q;
  reg route_info_q;
  reg restore_q;
  wire [`CDI_ST_W-1:0] ev_set = {nid_rx_in, restore_q, nid_fwd_q, route_info_q, nid_tx_q};

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: pready one cycle into access, write lands on the next edge, which samples pready high
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q <= `CDI_CTRL_RESET;
      blink_time_override_q <= 8'h00;
      mask_q <= {`CDI_ST_W{1'b0}};
      node_name_string_q <= 32'h00000000;
      own_addr_q <= 16'h0000;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      sim_go_q <= 1'b0;
      sim_cnt_q <= 3'h0;
    end else begin
      pready_q <= psel_in & penable_in & ~pready_q;
      pslverr_q <= psel_in & penable_in & ~pready_q & ~addr_ok;
      sim_go_q <= 1'b0;
      // Read data captured as pready rises
      if (psel_in & penable_in & ~pready_q) begin
        case (paddr_in)
          `CDI_REG_CTRL: prdata_q <= {24'h000000, ctrl_q};
          `CDI_REG_BLINK: prdata_q <= {24'h000000, blink_time_override_q};
          // [RULE2] Last packet strength
          `CDI_REG_RSSI: prdata_q <= {24'h000000, signal_strength_query_q};
          `CDI_REG_STATUS: prdata_q <= {27'h0000000, status_q};
          `CDI_REG_MASK: prdata_q <= {27'h0000000, mask_q};
          `CDI_REG_NAME: prdata_q <= node_name_string_q;
          `CDI_REG_ADDR: prdata_q <= {16'h0000, own_addr_q};
          // Simulation register and holes read zero
          default: prdata_q <= 32'h00000000;
        endcase
      end
      if (apb_wr) begin
        case (paddr_in)
          `CDI_REG_CTRL: ctrl_q <= pwdata_in[7:0];
          `CDI_REG_BLINK: blink_time_override_q <= pwdata_in[7:0];
          `CDI_REG_BTN: begin
            // [RULE14] Simulated press count
            sim_go_q <= 1'b1;
            sim_cnt_q <= pwdata_in[2:0];
          end
          `CDI_REG_MASK: mask_q <= pwdata_in[`CDI_ST_W-1:0];
          `CDI_REG_NAME: node_name_string_q <= pwdata_in;
          `CDI_REG_ADDR: own_addr_q <= pwdata_in[15:0];
          // Read-only or unmapped: ignored
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, set wins over write-one clear; masked irq
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_q <= {`CDI_ST_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      if (apb_wr && (paddr_in == `CDI_REG_STATUS)) begin
        status_q <= (status_q & ~pwdata_in[`CDI_ST_W-1:0]) | ev_set;
      end else begin
        status_q <= status_q | ev_set;
      end
      irq_q <= |(status_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick; long count is a parameter for short sims
  reg [31:0] tick_cnt_q;
  reg tick_q;
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 32'h00000000 : tick_cnt_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signal strength capture and PWM
  reg [7:0] pwm_cnt_q;
  reg [7:0] duty_q;
  reg pwm_q;
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      signal_strength_query_q <= 8'h00;
      duty_q <= 8'h00;
      pwm_cnt_q <= 8'h00;
      pwm_q <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      if (pkt_rx_in) begin
        // [RULE2] Magnitude in -dBm, last hop only
        signal_strength_query_q <= pkt_rssi_in;
        // [RULE3] Stronger signal, wider pulse
        duty_q <= 8'hff - pkt_rssi_in;
      end
      // [RULE3] Pin driven only when selected
      pwm_q <= ctrl_q[`CDI_CTRL_RSSI_SEL] & (pwm_cnt_q < duty_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pushbutton sync and debounce
  reg btn_s1_q;
  reg btn_s2_q;
  reg btn_db_q;
  reg [15:0] db_cnt_q;
  reg press_q;
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      btn_s1_q <= 1'b1;
      btn_s2_q <= 1'b1;
      btn_db_q <= 1'b1;
      db_cnt_q <= 16'h0000;
      press_q <= 1'b0;
    end else begin
      // [RULE16] Two-stage synchroniser
      btn_s1_q <= button_n_in;
      btn_s2_q <= btn_s1_q;
      press_q <= 1'b0;
      // [RULE16] Level must hold for the debounce time
      if (btn_s2_q == btn_db_q) begin
        db_cnt_q <= DEBOUNCE;
      end else if (tick_q) begin
        if (db_cnt_q == 16'h0001) begin
          btn_db_q <= btn_s2_q;
          press_q <= ~btn_s2_q;
        end
        db_cnt_q <= dec16(db_cnt_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Press counting window and actions
  reg [1:0] state_q;
  reg [15:0] win_cnt_q;
  reg [2:0] press_cnt_q;
  reg act_go;
  reg [2:0] act_cnt;
  // [RULE9] Pushbutton only when selected
  wire press_ok = press_q & ctrl_q[`CDI_CTRL_BTN_SEL];
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      win_cnt_q <= 16'h0000;
      press_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (press_ok) begin
            // [RULE10] First press opens window
            state_q <= ST_COUNT;
            win_cnt_q <= WINDOW;
            press_cnt_q <= 3'h1;
          end
        end
        ST_COUNT: begin
          if (press_ok && press_cnt_q != 3'h7) begin
            press_cnt_q <= press_cnt_q + 3'h1;
          end
          if (tick_q) begin
            win_cnt_q <= dec16(win_cnt_q);
            // [RULE10] Window closes, count acted on
            if (win_cnt_q == 16'h0001) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Action request from window close or simulation
  always @* begin
    act_go = 1'b0;
    act_cnt = 3'h0;
    if (sim_go_q) begin
      // [RULE14] Same path as real presses
      act_go = 1'b1;
      act_cnt = sim_cnt_q;
    end else if ((state_q == ST_COUNT) && tick_q && (win_cnt_q == 16'h0001)) begin
      act_go = 1'b1;
      act_cnt = press_cnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Broadcast, wake hold, restore, forwarding and route reports
  reg nid_pend_q;
  reg [15:0] wake_cnt_q;
  reg wake_hold_q;
  reg [15:0] nid_tx_addr_q;
  reg [31:0] nid_tx_name_q;
  reg [2:0] nid_tx_sleep_q;
  wire single = act_go && (act_cnt == `CDI_PRESS_NID);
  wire async_sleep = ctrl_q[`CDI_CTRL_ASYNC];
  wire send_now = (single && (!sleep_compat || async_sleep)) || (nid_pend_q && wake_start_in);
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nid_pend_q <= 1'b0;
      nid_tx_q <= 1'b0;
      wake_cnt_q <= 16'h0000;
      wake_hold_q <= 1'b0;
      restore_q <= 1'b0;
      nid_fwd_q <= 1'b0;
      nid_fwd_addr_q <= 16'h0000;
      route_info_q <= 1'b0;
      nid_tx_addr_q <= 16'h0000;
      nid_tx_name_q <= 32'h00000000;
      nid_tx_sleep_q <= 3'h0;
    end else begin
      // [RULE7] Now if awake-always or asynchronous sleep, else next wake start
      nid_tx_q <= send_now;
      if (send_now) begin
        nid_pend_q <= 1'b0;
        // [RULE15] Frame fields: address, name, sleep mode
        nid_tx_addr_q <= own_addr_q;
        nid_tx_name_q <= node_name_string_q;
        nid_tx_sleep_q <= sleep_mode;
      end else if (single && sleep_compat) begin
        nid_pend_q <= 1'b1;
      end
      // [RULE11] Thirty second wake under asynchronous sleep
      if (single && async_sleep) begin
        wake_cnt_q <= WAKE_DUR;
      end else if (tick_q) begin
        wake_cnt_q <= dec16(wake_cnt_q);
      end
      wake_hold_q <= (wake_cnt_q != 16'h0000);
      // [RULE12] Four presses restore defaults
      restore_q <= act_go && (act_cnt == `CDI_PRESS_RESTORE);
      // [RULE13] Forward received broadcast in API mode
      nid_fwd_q <= nid_rx_in & ctrl_q[`CDI_CTRL_API];
      if (nid_rx_in) begin
        nid_fwd_addr_q <= nid_rx_addr_in;
      end
      // [RULE1] NACK option reports failed hop
      route_info_q <= mac_ack_fail_in & tx_nack_opt_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Association indicator blinking
  reg [15:0] blink_cnt_q;
  reg [15:0] fast_cnt_q;
  reg led_phase_q;
  reg led_q;
  reg led_oe_q;
  // [RULE5] Zero override picks the default period
  wire [15:0] blink_ms = (blink_time_override_q == 8'h00) ? BLINK_DEF : blink_time_override_q * BLINK_UNIT;
  wire fast_on = (fast_cnt_q != 16'h0000);
  wire [15:0] half_ms = fast_on ? FAST_HALF : blink_ms;
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      blink_cnt_q <= 16'h0000;
      fast_cnt_q <= 16'h0000;
      led_phase_q <= 1'b0;
      led_q <= 1'b0;
      led_oe_q <= 1'b0;
    end else begin
      // [RULE8] One second of rapid blinking
      if (nid_rx_in && ctrl_q[`CDI_CTRL_ASSOC_SEL]) begin
        fast_cnt_q <= FAST_DUR;
      end else if (tick_q) begin
        fast_cnt_q <= dec16(fast_cnt_q);
      end
      // [RULE5] Phase toggles each blink time
      if (tick_q) begin
        if (blink_cnt_q + 16'h0001 >= half_ms) begin
          blink_cnt_q <= 16'h0000;
          led_phase_q <= ~led_phase_q;
        end else begin
          blink_cnt_q <= blink_cnt_q + 16'h0001;
        end
      end
      // [RULE4] Pin is an output only when selected
      led_oe_q <= ctrl_q[`CDI_CTRL_ASSOC_SEL];
      // [RULE6] Dark while asleep in a sleep mode
      led_q <= ctrl_q[`CDI_CTRL_ASSOC_SEL] & led_phase_q & (~sleep_compat | awake_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign rssi_pwm_pin_out = pwm_q;
  assign assoc_led_out = led_q;
  assign assoc_led_oe_out = led_oe_q;
  assign nid_tx_out = nid_tx_q;
  assign nid_tx_addr_out = nid_tx_addr_q;
  assign nid_tx_name_out = nid_tx_name_q;
  assign nid_tx_sleep_out = nid_tx_sleep_q;
  assign nid_fwd_out = nid_fwd_q;
  assign nid_fwd_addr_out = nid_fwd_addr_q;
  assign route_info_out = route_info_q;
  assign restore_defaults_out = restore_q;
  assign wake_hold_out = wake_hold_q;
  assign irq_out = irq_q;

endmodule // cdi_top
